/* logic/mfe_cfg.svh */
/*
 * Constants of the message-sequence frame engine: timing, checksum seed,
 * configuration field positions and buffer sizes.
 * Assumes it is included by bare name before any module that uses it.
 */
`ifndef MFE_CFG_SVH
`define MFE_CFG_SVH

// ****************************************************************
// Timing
// ****************************************************************
`define MFE_CLK_HZ        100000000
`define MFE_BAUD_COM3     230400
`define MFE_BAUD_COM2     38400
`define MFE_OVERSAMPLE    16
`define MFE_SAMPLE_PHASE  4'h7
`define MFE_LAST_PHASE    4'hF
`define MFE_GAP_BITS      4

// ****************************************************************
// Framing and checksum
// ****************************************************************
`define MFE_STOP_INDEX    4'hA
`define MFE_PARITY_INDEX  4'h9
`define MFE_CK_SEED       8'h52
`define MFE_TYPE_MASK     8'hC0

// ****************************************************************
// sequence_length_config fields
// ****************************************************************
`define MFE_CFG_CNT_LSB   0
`define MFE_CFG_OD2_LSB   4
`define MFE_CFG_OD1_LSB   6

// ****************************************************************
// Buffers
// ****************************************************************
`define MFE_BUF_OCTETS    15
`define MFE_FIFO_DEPTH    16

`endif

/* logic/mfe_pkg.sv */
/*
 * Types shared by the frame engine modules.
 * Assumes nothing of its surroundings.
 */
package mfe_pkg;

  typedef enum logic [2:0] {
    MFE_IDLE  = 3'b000,
    MFE_RBITS = 3'b001,
    MFE_RGAP  = 3'b010,
    MFE_WAIT  = 3'b011,
    MFE_TSEND = 3'b100
  } mfe_state_t;

endpackage

/* logic/mfe_line_filter.sv */
/*
 * Synchroniser and glitch filter for the incoming line level.
 * Assumes line_in is asynchronous and stable_max is on the clk domain.
 */
`timescale 1ns/10ps
`include "mfe_cfg.svh"

module mfe_line_filter #(
  parameter int CW = 8
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          line_in,
  input  wire logic [CW-1:0] stable_max,
  output logic               line_out
);

  logic          sync1_r;
  logic          sync2_r;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic          out_r;
  logic          out_nxt;

  // ****************************************************************
  // Stability counter
  // ****************************************************************
  always_comb begin
    cnt_nxt = '0;
    out_nxt = out_r;
    if (sync2_r != out_r) begin
      if (cnt_r == stable_max) begin
        out_nxt = sync2_r;
      end else begin
        cnt_nxt = cnt_r + {{(CW-1){1'b0}}, 1'b1};
      end
    end
  end

  // Line idles low, so the filter starts low too
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      cnt_r   <= '0;
      out_r   <= 1'b0;
    end else begin
      sync1_r <= line_in;
      sync2_r <= sync1_r;
      cnt_r   <= cnt_nxt;
      out_r   <= out_nxt;
    end
  end

  assign line_out = out_r;

endmodule

/* logic/mfe_fifo.sv */
/*
 * Reply-octet FIFO with valid/ready on both sides and a flush.
 * Assumes both sides run on clk; out_data is valid while out_valid is high.
 */
`timescale 1ns/10ps
`include "mfe_cfg.svh"

module mfe_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = `MFE_FIFO_DEPTH
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         flush,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW-1:0] LAST  = AW'(DEPTH - 1);
  localparam logic [AW:0]   FULLC = (AW+1)'(DEPTH);

  logic [W-1:0]  mem_r [0:DEPTH-1];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] wp_nxt;
  logic [AW-1:0] rp_r;
  logic [AW-1:0] rp_nxt;
  logic [AW:0]   cnt_r;
  logic [AW:0]   cnt_nxt;
  logic          rdy_r;
  logic          push;
  logic          pop;

  // ****************************************************************
  // Pointers and count
  // ****************************************************************
  always_comb begin
    push    = in_valid && rdy_r;
    pop     = out_ready && (cnt_r != '0);
    wp_nxt  = wp_r;
    rp_nxt  = rp_r;
    cnt_nxt = cnt_r;
    if (push) begin
      wp_nxt = (wp_r == LAST) ? '0 : wp_r + {{(AW-1){1'b0}}, 1'b1};
    end
    if (pop) begin
      rp_nxt = (rp_r == LAST) ? '0 : rp_r + {{(AW-1){1'b0}}, 1'b1};
    end
    if (push && !pop) begin
      cnt_nxt = cnt_r + {{AW{1'b0}}, 1'b1};
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - {{AW{1'b0}}, 1'b1};
    end
    if (flush) begin
      wp_nxt  = '0;
      rp_nxt  = '0;
      cnt_nxt = '0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
      rdy_r <= 1'b1;
    end else begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
      rdy_r <= (cnt_nxt != FULLC);
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end

  assign in_ready  = rdy_r;
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem_r[rp_r];

endmodule

/* logic/mfe_frame_engine.sv */
/*
 * Message-sequence frame engine: receives master frames, checks parity and
 * checksum, holds the message for the microcontroller and sends the reply.
 * Assumes all register-side ports are on REF_CLK; CQ_LINE_IN is asynchronous.
 */
// What this block does
// [RQ1] Direction comes from bit 7 of the first octet; one means master read.
// [RQ2] Sequence type comes from bits 7:6 of the second octet.
// [RQ3] Expected length from type and direction, with on-demand and count fields.
// [RQ4] Type 1 on-demand: 01 two, 10 eight; 00 uses count plus type 2 octets.
// [RQ5] Type 2 on-demand: 00 one, 01 two, 10 eight; 32 not supported.
// [RQ6] Four-bit count field gives type 2 read length and write base.
// [RQ7] Message buffer holds 15 octets; longer messages need single-octet mode. No such mode here: octets past the fifteenth are counted, not stored.
// [RQ8] Transmit checksum XORs all counted octets from 0x52; last octet checksum zero.
// [RQ9] Eight-bit XOR result is compacted to six bits by fixed XORs: pairs for the low four, alternate bits for the top two.
// [RQ10] Checksum fills low six bits of final octet; top two bits kept.
// [RQ11] Receive checksum from 0x52, type octet checksum bits zeroed, then compared.
// [RQ12] One select bit picks the line rate for both directions.
// [RQ13] Incoming line pulses shorter than a sixteenth bit are filtered out.
// [RQ14] First transition is frame reference; bits sampled mid-bit; fill count kept.
// [RQ15] After expected frames, check, set flags and raise an interrupt.
// [RQ16] Gap over four bits sets both flags and raises an interrupt.
// [RQ17] After reception wait until send or end is requested.
// [RQ18] Reply count plus send: frame each octet and insert the checksum.
// [RQ19] Reply drives the line push-pull, timed by the engine clock.
// [RQ20] Send or end clears the received and checksum flags.
// [RQ21] Reply start adds at most a sixteenth bit of alignment delay.
// [RQ22] Frame: start zero, eight data LSB first, even parity, stop one.
// [RQ23] Logical one is a low line level; the line idles low.
// [RQ24] Gap counter restarts after each stop bit and clears on a start.
// [RQ25] Parity errors report through the checksum error flag.
`timescale 1ns/10ps
`include "mfe_cfg.svh"

module mfe_frame_engine #(
  parameter int TICK_HI_CYC = `MFE_CLK_HZ / (`MFE_OVERSAMPLE * `MFE_BAUD_COM3),
  parameter int TICK_LO_CYC = `MFE_CLK_HZ / (`MFE_OVERSAMPLE * `MFE_BAUD_COM2)
) (
  input  wire logic       REF_CLK,
  input  wire logic       NRST,
  input  wire logic       CQ_LINE_IN,
  input  wire logic [7:0] SEQ_LEN_CFG,
  input  wire logic       BIT_RATE_SELECT,
  input  wire logic [3:0] RD_INDEX,
  input  wire logic [7:0] TX_DATA,
  input  wire logic       TX_VALID,
  output logic            TX_READY,
  input  wire logic [3:0] TX_COUNT,
  input  wire logic       SEND_REQUEST,
  input  wire logic       END_REQUEST,
  output logic [7:0]      RD_DATA,
  output logic [3:0]      BUFFER_FILL_COUNT,
  output logic            MASTER_READ,
  output logic            MESSAGE_RECEIVED_FLAG,
  output logic            CHECKSUM_ERROR_FLAG,
  output logic            MSG_IRQ,
  output logic            CQ_DRIVE_LEVEL,
  output logic            CQ_HS_ON,
  output logic            CQ_LS_ON
);

  localparam logic [7:0] TICK_HI   = 8'(TICK_HI_CYC - 1);
  localparam logic [7:0] TICK_LO   = 8'(TICK_LO_CYC - 1);
  localparam logic [6:0] GAP_TICKS = 7'(`MFE_GAP_BITS * `MFE_OVERSAMPLE + `MFE_OVERSAMPLE / 2);
  localparam logic [4:0] BUF_N     = 5'(`MFE_BUF_OCTETS);

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  function automatic logic [5:0] compact(input logic [7:0] d);
    compact = {d[7] ^ d[5] ^ d[3] ^ d[1], d[6] ^ d[4] ^ d[2] ^ d[0],
               d[7] ^ d[6], d[5] ^ d[4], d[3] ^ d[2], d[1] ^ d[0]};  // [RQ9]
  endfunction

  function automatic logic [4:0] exp_len(input logic rd, input logic [1:0] typ,
                                         input logic [7:0] cfg);
    logic [4:0] m2;
    logic [4:0] f1;
    logic [4:0] f2;
    logic [1:0] od1;
    logic [1:0] od2;
    od1 = cfg[`MFE_CFG_OD1_LSB +: 2];
    od2 = cfg[`MFE_CFG_OD2_LSB +: 2];
    m2  = {1'b0, cfg[`MFE_CFG_CNT_LSB +: 4]};  // [RQ6]
    // Unsupported 32-octet width falls back to one octet
    f2  = (od2 == 2'b01) ? 5'h02 : (od2 == 2'b10) ? 5'h08 : 5'h01;  // [RQ5]
    f1  = (od1 == 2'b01) ? 5'h02 : 5'h08;  // [RQ4]
    case (typ)
      2'b00:   exp_len = rd ? 5'h02 : 5'h03;  // [RQ3]
      2'b01:   exp_len = (od1 == 2'b00) ? m2 + f2 : (rd ? 5'h02 : 5'h02 + f1);  // [RQ4]
      2'b10:   exp_len = rd ? m2 : m2 + f2;  // [RQ3]
      default: exp_len = 5'h02;
    endcase
  endfunction

  // ****************************************************************
  // Line filter and reply FIFO
  // ****************************************************************
  logic [7:0] tick_max;
  logic       line_f;
  logic       rx_bit;
  logic [7:0] fifo_data;
  logic       fifo_valid;
  logic       fifo_pop;
  logic       fifo_flush;

  assign tick_max = BIT_RATE_SELECT ? TICK_HI : TICK_LO;  // [RQ12]
  assign rx_bit   = ~line_f;  // [RQ23]

  mfe_line_filter #(
    .CW (8)
  ) u_filter (
    .clk        (REF_CLK),
    .rst_n      (NRST),
    .line_in    (CQ_LINE_IN),
    .stable_max (tick_max),  // [RQ13]
    .line_out   (line_f)
  );

  mfe_fifo #(
    .W     (8),
    .DEPTH (`MFE_FIFO_DEPTH)
  ) u_fifo (
    .clk       (REF_CLK),
    .rst_n     (NRST),
    .flush     (fifo_flush),
    .in_data   (TX_DATA),
    .in_valid  (TX_VALID),
    .in_ready  (TX_READY),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  // ****************************************************************
  // State
  // ****************************************************************
  mfe_pkg::mfe_state_t st_r, st_nxt;
  logic [7:0]  tick_r,  tick_nxt;
  logic [3:0]  sub_r,   sub_nxt;
  logic [3:0]  idx_r,   idx_nxt;
  logic [7:0]  sh_r,    sh_nxt;
  logic        par_r,   par_nxt;
  logic        prev_r,  prev_nxt;
  logic [6:0]  gap_r,   gap_nxt;
  logic [4:0]  cnt_r,   cnt_nxt;
  logic [4:0]  exp_r,   exp_nxt;
  logic        dir_r,   dir_nxt;
  logic [1:0]  typ_r,   typ_nxt;
  logic [5:0]  rck_r,   rck_nxt;
  logic [7:0]  acc_r,   acc_nxt;
  logic        perr_r,  perr_nxt;
  logic        dat_r,   dat_nxt;
  logic        chk_r,   chk_nxt;
  logic        irq_r,   irq_nxt;
  logic        txa_r,   txa_nxt;
  logic [10:0] txs_r,   txs_nxt;
  logic [3:0]  left_r,  left_nxt;
  logic        lvl_r,   lvl_nxt;
  logic        hs_r,    hs_nxt;
  logic        ls_r,    ls_nxt;
  logic [7:0]  rd_r,    rd_nxt;
  logic [3:0]  fill_r,  fill_nxt;
  logic [7:0]  buf_r [0:`MFE_BUF_OCTETS-1];
  logic        buf_we;
  logic [3:0]  buf_wa;
  logic        tick;
  logic        set_dat;
  logic        set_chk;
  logic [4:0]  cnt_inc;
  logic [4:0]  need;
  logic [7:0]  oct;
  logic [7:0]  d;
  logic        perr_now;

  assign tick = (tick_r == tick_max);

  always_comb begin
    st_nxt   = st_r;
    tick_nxt = tick ? 8'h00 : tick_r + 8'h01;
    sub_nxt  = tick ? sub_r + 4'h1 : sub_r;
    idx_nxt  = idx_r;
    sh_nxt   = sh_r;
    par_nxt  = par_r;
    prev_nxt = rx_bit;
    gap_nxt  = gap_r;
    cnt_nxt  = cnt_r;
    exp_nxt  = exp_r;
    dir_nxt  = dir_r;
    typ_nxt  = typ_r;
    rck_nxt  = rck_r;
    acc_nxt  = acc_r;
    perr_nxt = perr_r;
    irq_nxt  = 1'b0;
    txa_nxt  = txa_r;
    txs_nxt  = txs_r;
    left_nxt = left_r;
    set_dat  = 1'b0;
    set_chk  = 1'b0;
    buf_we   = 1'b0;
    buf_wa   = cnt_r[3:0];
    fifo_pop   = 1'b0;
    fifo_flush = 1'b0;
    cnt_inc  = cnt_r + 5'h01;
    need     = exp_r;
    oct      = sh_r;
    d        = 8'h00;
    perr_now = par_r | ~rx_bit;
    case (st_r)
      mfe_pkg::MFE_IDLE, mfe_pkg::MFE_RGAP: begin
        if (st_r == mfe_pkg::MFE_RGAP && tick) begin
          gap_nxt = gap_r + 7'h01;
        end
        if (prev_r && !rx_bit) begin
          tick_nxt = 8'h00;  // [RQ14]
          sub_nxt  = 4'h0;
          idx_nxt  = 4'h0;
          par_nxt  = 1'b0;
          gap_nxt  = 7'h00;  // [RQ24]
          st_nxt   = mfe_pkg::MFE_RBITS;
          if (st_r == mfe_pkg::MFE_IDLE) begin
            cnt_nxt  = 5'h00;
            acc_nxt  = `MFE_CK_SEED;  // [RQ11]
            perr_nxt = 1'b0;
            exp_nxt  = 5'h1F;
          end
        end else if (st_r == mfe_pkg::MFE_RGAP && gap_r == GAP_TICKS) begin
          set_dat = 1'b1;  // [RQ16]
          set_chk = 1'b1;
          irq_nxt = 1'b1;
          st_nxt  = mfe_pkg::MFE_WAIT;
        end
      end
      mfe_pkg::MFE_RBITS: begin
        if (tick && sub_r == `MFE_SAMPLE_PHASE) begin
          if (idx_r == 4'h0 && rx_bit) begin
            // False start: a glitch that outlived the filter
            st_nxt = (cnt_r == 5'h00) ? mfe_pkg::MFE_IDLE : mfe_pkg::MFE_RGAP;
          end else if (idx_r != 4'h0 && idx_r < `MFE_PARITY_INDEX) begin
            sh_nxt  = {rx_bit, sh_r[7:1]};  // [RQ22]
            par_nxt = par_r ^ rx_bit;
          end else if (idx_r == `MFE_PARITY_INDEX) begin
            par_nxt = par_r ^ rx_bit;  // [RQ22]
          end else if (idx_r == `MFE_STOP_INDEX) begin
            perr_nxt = perr_r | perr_now;  // [RQ25]
            buf_we   = (cnt_r < BUF_N);  // [RQ7]
            cnt_nxt  = cnt_inc;  // [RQ14]
            if (cnt_r == 5'h00) begin
              dir_nxt = oct[7];  // [RQ1]
              acc_nxt = acc_r ^ oct;
            end else if (cnt_r == 5'h01) begin
              typ_nxt = oct[7:6];  // [RQ2]
              rck_nxt = oct[5:0];
              acc_nxt = acc_r ^ (oct & `MFE_TYPE_MASK);  // [RQ11]
              need    = exp_len(dir_r, oct[7:6], SEQ_LEN_CFG);  // [RQ3]
              exp_nxt = need;
            end else begin
              acc_nxt = acc_r ^ oct;
            end
            gap_nxt = 7'h00;  // [RQ24]
            st_nxt  = mfe_pkg::MFE_RGAP;
            if (cnt_inc >= 5'h02 && cnt_inc >= need) begin
              set_dat = 1'b1;  // [RQ15]
              set_chk = perr_nxt || (compact(acc_nxt) != rck_nxt) || (typ_nxt == 2'b11);
              irq_nxt = 1'b1;
              st_nxt  = mfe_pkg::MFE_WAIT;  // [RQ17]
            end
          end
        end
        if (tick && sub_r == `MFE_LAST_PHASE) begin
          idx_nxt = idx_r + 4'h1;
        end
      end
      mfe_pkg::MFE_WAIT: begin
        if (SEND_REQUEST) begin
          left_nxt = TX_COUNT;  // [RQ18]
          acc_nxt  = `MFE_CK_SEED;  // [RQ8]
          txa_nxt  = 1'b0;
          cnt_nxt  = 5'h00;
          st_nxt   = mfe_pkg::MFE_TSEND;
        end else if (END_REQUEST) begin
          fifo_flush = 1'b1;
          cnt_nxt    = 5'h00;
          st_nxt     = mfe_pkg::MFE_IDLE;  // [RQ17]
        end
      end
      mfe_pkg::MFE_TSEND: begin
        if (!txa_r) begin
          if (left_r == 4'h0) begin
            st_nxt = mfe_pkg::MFE_IDLE;
          end else if (fifo_valid) begin
            fifo_pop = 1'b1;
            d        = acc_r ^ fifo_data;  // [RQ8]
            acc_nxt  = d;
            oct      = (left_r == 4'h1) ? {fifo_data[7:6], compact(d)} : fifo_data;  // [RQ10]
            txs_nxt  = {1'b1, ^oct, oct, 1'b0};  // [RQ22]
            txa_nxt  = 1'b1;
            idx_nxt  = 4'h0;
            tick_nxt = 8'h00;  // [RQ21]
            sub_nxt  = 4'h0;
          end
        end else if (tick && sub_r == `MFE_LAST_PHASE) begin
          if (idx_r == `MFE_STOP_INDEX) begin
            txa_nxt  = 1'b0;
            left_nxt = left_r - 4'h1;
          end else begin
            txs_nxt = {1'b1, txs_r[10:1]};
            idx_nxt = idx_r + 4'h1;
          end
        end
      end
      default: begin
        st_nxt = mfe_pkg::MFE_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // Flags, line drive and read port
  // ****************************************************************
  always_comb begin
    // A new event outranks a clear arriving in the same cycle
    dat_nxt = (dat_r & ~(SEND_REQUEST | END_REQUEST)) | set_dat;  // [RQ20]
    chk_nxt = (chk_r & ~(SEND_REQUEST | END_REQUEST)) | set_chk;  // [RQ20]
    if (st_r == mfe_pkg::MFE_TSEND) begin
      lvl_nxt = txa_r ? ~txs_r[0] : 1'b0;  // [RQ23]
      hs_nxt  = lvl_nxt;  // [RQ19]
      ls_nxt  = ~lvl_nxt;
    end else begin
      lvl_nxt = 1'b0;
      hs_nxt  = 1'b0;
      ls_nxt  = 1'b0;
    end
    rd_nxt = (RD_INDEX < 4'(`MFE_BUF_OCTETS)) ? buf_r[RD_INDEX] : 8'h00;
    fill_nxt = (cnt_nxt > BUF_N) ? 4'hF : cnt_nxt[3:0];
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      st_r   <= mfe_pkg::MFE_IDLE;
      tick_r <= 8'h00;
      sub_r  <= 4'h0;
      idx_r  <= 4'h0;
      sh_r   <= 8'h00;
      par_r  <= 1'b0;
      prev_r <= 1'b1;
      gap_r  <= 7'h00;
      cnt_r  <= 5'h00;
      exp_r  <= 5'h1F;
      dir_r  <= 1'b0;
      typ_r  <= 2'b00;
      rck_r  <= 6'h00;
      acc_r  <= `MFE_CK_SEED;
      perr_r <= 1'b0;
      dat_r  <= 1'b0;
      chk_r  <= 1'b0;
      irq_r  <= 1'b0;
      txa_r  <= 1'b0;
      txs_r  <= 11'h7FF;
      left_r <= 4'h0;
      lvl_r  <= 1'b0;
      hs_r   <= 1'b0;
      ls_r   <= 1'b0;
      rd_r   <= 8'h00;
      fill_r <= 4'h0;
    end else begin
      st_r   <= st_nxt;
      tick_r <= tick_nxt;
      sub_r  <= sub_nxt;
      idx_r  <= idx_nxt;
      sh_r   <= sh_nxt;
      par_r  <= par_nxt;
      prev_r <= prev_nxt;
      gap_r  <= gap_nxt;
      cnt_r  <= cnt_nxt;
      exp_r  <= exp_nxt;
      dir_r  <= dir_nxt;
      typ_r  <= typ_nxt;
      rck_r  <= rck_nxt;
      acc_r  <= acc_nxt;
      perr_r <= perr_nxt;
      dat_r  <= dat_nxt;
      chk_r  <= chk_nxt;
      irq_r  <= irq_nxt;
      txa_r  <= txa_nxt;
      txs_r  <= txs_nxt;
      left_r <= left_nxt;
      lvl_r  <= lvl_nxt;
      hs_r   <= hs_nxt;
      ls_r   <= ls_nxt;
      rd_r   <= rd_nxt;
      fill_r <= fill_nxt;
    end
  end

  // Octets past the fifteenth are counted and checked but not stored
  always_ff @(posedge REF_CLK) begin
    if (buf_we) begin
      buf_r[buf_wa] <= sh_r;  // [RQ7]
    end
  end

  assign RD_DATA               = rd_r;
  assign BUFFER_FILL_COUNT     = fill_r;
  assign MASTER_READ           = dir_r;
  assign MESSAGE_RECEIVED_FLAG = dat_r;
  assign CHECKSUM_ERROR_FLAG   = chk_r;
  assign MSG_IRQ               = irq_r;
  assign CQ_DRIVE_LEVEL        = lvl_r;
  assign CQ_HS_ON              = hs_r;
  assign CQ_LS_ON              = ls_r;

endmodule

/* dv/mfe_frame_engine_sva.sv */
/* Port checker for the message-sequence frame engine.
   Assumes binding onto mfe_frame_engine with the same tick parameters. */
`timescale 1ns/10ps
module mfe_frame_engine_sva #(
  parameter int TICK_HI_CYC = 27,
  parameter int TICK_LO_CYC = 162
) (
  input wire logic       REF_CLK,
  input wire logic       NRST,
  input wire logic       BIT_RATE_SELECT,
  input wire logic       SEND_REQUEST,
  input wire logic       END_REQUEST,
  input wire logic [3:0] BUFFER_FILL_COUNT,
  input wire logic       MASTER_READ,
  input wire logic       MESSAGE_RECEIVED_FLAG,
  input wire logic       CHECKSUM_ERROR_FLAG,
  input wire logic       MSG_IRQ,
  input wire logic       CQ_DRIVE_LEVEL,
  input wire logic       CQ_HS_ON,
  input wire logic       CQ_LS_ON
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!NRST);
  logic [11:0] hi_run_r;
  logic [11:0] hi_run_nxt;
  logic        drv;
  int          bit_cyc;
  assign drv = CQ_HS_ON | CQ_LS_ON;
  assign bit_cyc = 16 * (BIT_RATE_SELECT ? TICK_HI_CYC : TICK_LO_CYC);
  // Only high runs: low idle between reply frames has no fixed length
  always_comb begin
    hi_run_nxt = (drv && CQ_DRIVE_LEVEL) ? hi_run_r + 12'h001 : 12'h000;
  end
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      hi_run_r <= 12'h000;
    end else begin
      hi_run_r <= hi_run_nxt;
    end
  end
  a_irq_one_cycle: assert property (MSG_IRQ |=> !MSG_IRQ)
    else $error("irq pulse too long");
  a_irq_with_flag: assert property (MSG_IRQ |-> MESSAGE_RECEIVED_FLAG)
    else $error("irq without data flag");
  a_flag_rise_irq: assert property ($rose(MESSAGE_RECEIVED_FLAG) |-> MSG_IRQ)
    else $error("data flag rose without irq");
  a_chk_with_data: assert property ($rose(CHECKSUM_ERROR_FLAG) |-> MESSAGE_RECEIVED_FLAG)
    else $error("checksum flag alone");
  a_dat_clear: assert property ((SEND_REQUEST || END_REQUEST) |=>
    !MESSAGE_RECEIVED_FLAG || MSG_IRQ) else $error("data flag not cleared");
  a_chk_clear: assert property ((SEND_REQUEST || END_REQUEST) |=>
    !CHECKSUM_ERROR_FLAG || MSG_IRQ) else $error("checksum flag not cleared");
  a_push_pull: assert property (drv |-> CQ_HS_ON == CQ_DRIVE_LEVEL
    && CQ_LS_ON == !CQ_DRIVE_LEVEL) else $error("switches disagree with level");
  a_wait_quiet: assert property (MESSAGE_RECEIVED_FLAG |-> !drv)
    else $error("line driven while waiting");
  a_whole_bits: assert property (drv && !CQ_DRIVE_LEVEL && hi_run_r != 0 |->
    hi_run_r % bit_cyc == 0 && hi_run_r <= 10 * bit_cyc) else $error("bad bit length");
  a_msg_stable: assert property (MESSAGE_RECEIVED_FLAG && $past(MESSAGE_RECEIVED_FLAG) |->
    $stable(MASTER_READ) && $stable(BUFFER_FILL_COUNT)) else $error("message view moved");
endmodule
bind mfe_frame_engine mfe_frame_engine_sva #(
  .TICK_HI_CYC(TICK_HI_CYC),
  .TICK_LO_CYC(TICK_LO_CYC)
) i_mfe_frame_engine_sva (.REF_CLK(REF_CLK), .NRST(NRST), .BIT_RATE_SELECT(BIT_RATE_SELECT),
  .SEND_REQUEST(SEND_REQUEST), .END_REQUEST(END_REQUEST),
  .BUFFER_FILL_COUNT(BUFFER_FILL_COUNT), .MASTER_READ(MASTER_READ),
  .MESSAGE_RECEIVED_FLAG(MESSAGE_RECEIVED_FLAG), .CHECKSUM_ERROR_FLAG(CHECKSUM_ERROR_FLAG),
  .MSG_IRQ(MSG_IRQ), .CQ_DRIVE_LEVEL(CQ_DRIVE_LEVEL), .CQ_HS_ON(CQ_HS_ON), .CQ_LS_ON(CQ_LS_ON));

/* dv/mfe_master_model.sv */
/* Line master model: sends frames on the line and decodes reply frames.
   Assumes the caller sets bit_cyc and calls send just after a falling edge. */
`timescale 1ns/10ps
module mfe_master_model (
  input wire logic       clk,
  input wire logic [7:0] bit_cyc,
  input wire logic       dev_on,
  input wire logic       dev_level,
  output logic           line
);
  logic [9:0] rx_q[$];
  logic [9:0] rx_b;
  initial line = 1'b0;
  // Frames sent back to back, so the gap never exceeds four bits
  task automatic send(input logic [7:0] d, input logic perr);
    logic [10:0] f;
    f = {1'b1, ^d ^ perr, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      line = ~f[i];
      repeat (bit_cyc) @(negedge clk);
    end
  endtask
  // Reply decode: start on high level, sample at bit centres
  always begin
    @(negedge clk);
    if (dev_on && dev_level) begin
      repeat (bit_cyc / 2) @(negedge clk);
      for (int i = 0; i < 10; i++) begin
        repeat (bit_cyc) @(negedge clk);
        rx_b[i] = ~dev_level;
      end
      rx_q.push_back(rx_b);
    end
  end
endmodule

/* dv/testbench.sv */
/* Self-checking bench for the frame engine: table of received messages,
   then one reply. Assumes the master model and the bound checker. */
`timescale 1ns/10ps
module testbench;
  localparam int TK_HI = 4;
  localparam int TK_LO = 6;
  // cfg, control, type, count, flaw (1 checksum, 2 parity, 3 short), fast
  localparam logic [31:0] TC [14] = '{32'h0000_0031, 32'h0080_0021, 32'h8000_40A1,
    32'h4080_4021, 32'h4000_4041, 32'h1380_4051, 32'h0480_8041, 32'h0300_8041,
    32'h2700_80F1, 32'h1200_8045, 32'h0000_0039, 32'h0080_0020, 32'h3200_8031, 32'h0000_003D};
  logic       clk, nrst, brs, txv, txr, snd, endr, mrd, dat, chk, irq, lvl, hs, ls, mline;
  logic [7:0] cfg, rdd, txd;
  logic [3:0] rdi, txc, fill;
  logic [7:0] m [16];
  int         num_errors, check_count, cyc, irq_n;
  wire        cq = (hs | ls) ? lvl : mline;
  mfe_frame_engine #(.TICK_HI_CYC(TK_HI), .TICK_LO_CYC(TK_LO)) i_mfe_frame_engine (
    .REF_CLK(clk), .NRST(nrst), .CQ_LINE_IN(cq), .SEQ_LEN_CFG(cfg), .BIT_RATE_SELECT(brs),
    .RD_INDEX(rdi), .TX_DATA(txd), .TX_VALID(txv), .TX_READY(txr), .TX_COUNT(txc),
    .SEND_REQUEST(snd), .END_REQUEST(endr), .RD_DATA(rdd), .BUFFER_FILL_COUNT(fill),
    .MASTER_READ(mrd), .MESSAGE_RECEIVED_FLAG(dat), .CHECKSUM_ERROR_FLAG(chk),
    .MSG_IRQ(irq), .CQ_DRIVE_LEVEL(lvl), .CQ_HS_ON(hs), .CQ_LS_ON(ls));
  mfe_master_model i_mfe_master_model (.clk(clk), .bit_cyc(8'(16 * (brs ? TK_HI : TK_LO))),
    .dev_on(hs | ls), .dev_level(lvl), .line(mline));
  function automatic logic [5:0] ck6(input logic [7:0] d);
    return {d[7]^d[5]^d[3]^d[1], d[6]^d[4]^d[2]^d[0], d[7]^d[6], d[5]^d[4], d[3]^d[2], d[1]^d[0]};
  endfunction
  task check(input logic [9:0] got, input logic [9:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task finish_test;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task step(input int n);
    repeat (n) @(negedge clk);
  endtask
  task pulse_req(input logic s);
    snd = s;
    endr = !s;
    step(1);
    snd = 1'b0;
    endr = 1'b0;
    step(1);
    check(dat, 0, "data flag");
    check(chk, 0, "chk flag");
  endtask
  task run_case(input logic [31:0] t);
    logic [7:0] x;
    int         n;
    int         fl;
    n = t[7:4];
    irq_n = 0;
    fl = t[3:2];
    cfg = t[31:24];
    brs = t[0];
    x = 8'h52 ^ t[23:16] ^ (t[15:8] & 8'hC0);
    m[0] = t[23:16];
    for (int i = 2; i < n; i++) begin
      m[i] = 8'h30 + 8'(i);
      x ^= m[i];
    end
    m[1] = {t[15:14], ck6(x) ^ 6'(fl == 1)};
    step(2);
    for (int i = 0; i < n - (fl == 3); i++) i_mfe_master_model.send(m[i], fl == 2 && i == n - 1);
    for (int i = 0; i < 1000 && irq_n == 0; i++) step(1);
    check(irq_n, 1, "irq");
    check(dat, 1, "data flag");
    check(chk, fl != 0, "chk flag");
    check(mrd, t[23], "direction");
    check(fill, n - (fl == 3), "fill");
    for (int i = 0; i < n - (fl == 3); i++) begin
      rdi = 4'(i);
      step(1);
      check(rdd, m[i], "buffer");
    end
  endtask
  always @(negedge clk) if (irq === 1'b1) irq_n++;
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      num_errors++;
      $display("[FAIL] %0t timeout", $time);
      finish_test();
    end
  end
  initial begin
    {nrst, brs, txv, snd, endr, cfg, rdi, txd, txc} = '0;
    step(20);
    nrst = 1'b1;
    step(5);
    check(txr, 1, "fifo ready");
    for (int k = 0; k < 14; k++) begin
      run_case(TC[k]);
      if (k < 13) pulse_req(1'b0);
      $display("case %0d done", k);
    end
    m[0] = 8'h11;
    m[1] = 8'h22;
    m[2] = 8'hC0;
    for (int i = 0; i < 3; i++) begin
      txd = m[i];
      txv = 1'b1;
      step(1);
    end
    txv = 1'b0;
    m[2][5:0] = ck6(8'h52 ^ 8'h11 ^ 8'h22 ^ 8'hC0);
    txc = 4'h3;
    pulse_req(1'b1);
    for (int i = 0; i < 3000 && i_mfe_master_model.rx_q.size() < 3; i++) step(1);
    check(10'(i_mfe_master_model.rx_q.size()), 3, "reply count");
    for (int i = 0; i < 3; i++) begin
      check(i_mfe_master_model.rx_q[i], {1'b1, ^m[i], m[i]}, "reply");
    end
    $display("reply done");
    finish_test();
  end
endmodule
